/* File: verilog/vcub_bridge.sv */
// UART bridge between target processor and board controller host paths
// Overview of operation
// - After reset the link runs at 115200 bit/s, 8N1, with flow control disabled.
// - The baud divider is software-set for any rate from 9600 to 921600 bit/s.
// - Target output line feeds the receiver; the target input line carries our transmitter.
// - In modes rts and rtscts, clear-to-send drops whenever the receive buffer is full.
// - When honouring request-to-send, no new character starts while it is low.
// - A character already being sent completes after request-to-send drops.
// - Mode disable leaves clear-to-send undriven and ignores request-to-send.
// - Mode rts drives clear-to-send from buffer state and ignores request-to-send.
// - Mode cts leaves clear-to-send undriven and starts a character only while request-to-send is high.
// - Mode rtscts both drives clear-to-send and gates sending on request-to-send.
// - Data goes to one host path only; a connected socket silences the USB path.
//
// Added by the designer: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module vcub_bridge #(
   parameter logic [15:0] DIV_RESET = vcub_pkg::DIV_DEFAULT
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic targetTx,
   output logic targetRx,
   input wire logic targetRts,
   output logic targetCts,
   output logic targetCtsOe,
   input wire logic bridgeEnable,
   output logic usbPathActive,
   output logic socketPathActive
);
   if (DIV_RESET < vcub_pkg::DIV_MIN || DIV_RESET > vcub_pkg::DIV_MAX) begin : gDivCheck
      $error("DIV_RESET outside supported baud range");
   end
   // Pin synchronisers
   logic [1:0] txSync, rtsSync, enSync;
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         txSync <= 2'h3;
         rtsSync <= 2'h0;
         enSync <= 2'h0;
      end else begin
         txSync <= {txSync[0], targetTx};
         rtsSync <= {rtsSync[0], targetRts};
         enSync <= {enSync[0], bridgeEnable};
      end
   end
   logic rxLine, rtsIn, linkOn;
   assign rxLine = txSync[1];
   assign rtsIn = rtsSync[1];
   assign linkOn = enSync[1];
   // Configuration registers
   logic [2:0] ctrlReg;
   logic [15:0] divReg;
   vcub_pkg::vcub_hs_e hsMode;
   assign hsMode = vcub_pkg::vcub_hs_e'(ctrlReg[vcub_pkg::CTRL_HS_LSB +: 2]);
   function automatic logic drivesCts(input vcub_pkg::vcub_hs_e m);
      return (m == vcub_pkg::VCUB_HS_RTS) || (m == vcub_pkg::VCUB_HS_RTSCTS);
   endfunction
   function automatic logic honoursRts(input vcub_pkg::vcub_hs_e m);
      return (m == vcub_pkg::VCUB_HS_CTS) || (m == vcub_pkg::VCUB_HS_RTSCTS);
   endfunction
   // Sixteen-times oversample tick
   logic [15:0] tickCnt;
   logic tick;
   assign tick = (tickCnt == 16'h0000);
   always_ff @(posedge clk_sys) begin
      if (!rst_n || tick) begin
         tickCnt <= !rst_n ? DIV_RESET : divReg;
      end else begin
         tickCnt <= tickCnt - 16'h0001;
      end
   end

   // Receiver from the target output line
   vcub_pkg::vcub_state_e rxState;
   logic [3:0] rxPhase;
   logic [2:0] rxBit;
   logic [7:0] rxShift, rxData;
   logic rxValid, rxOverrun, rxFrameErr, rxDone, rxTake, rxStopOk;
   assign rxDone = tick && (rxState == vcub_pkg::VCUB_STOP) && (rxPhase == 4'hf);
   assign rxStopOk = rxLine;
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rxState <= vcub_pkg::VCUB_IDLE;
         rxPhase <= 4'h0;
         rxBit <= 3'h0;
         rxShift <= 8'h00;
      end else if (!linkOn) begin
         rxState <= vcub_pkg::VCUB_IDLE;
      end else if (tick) begin
         rxPhase <= rxPhase + 4'h1;
         case (rxState)
            vcub_pkg::VCUB_IDLE: begin
               rxPhase <= 4'h0;
               if (!rxLine) begin
                  rxState <= vcub_pkg::VCUB_START;
               end
            end
            vcub_pkg::VCUB_START: begin
               if (rxPhase == 4'h7) begin
                  rxPhase <= 4'h0;
                  rxState <= rxLine ? vcub_pkg::VCUB_IDLE : vcub_pkg::VCUB_DATA;
                  rxBit <= 3'h0;
               end
            end
            vcub_pkg::VCUB_DATA: begin
               if (rxPhase == 4'hf) begin
                  rxShift <= {rxLine, rxShift[7:1]};
                  rxBit <= rxBit + 3'h1;
                  if (rxBit == 3'h7) begin
                     rxState <= vcub_pkg::VCUB_STOP;
                  end
               end
            end
            vcub_pkg::VCUB_STOP: begin
               if (rxPhase == 4'hf) begin
                  rxState <= vcub_pkg::VCUB_IDLE;
               end
            end
            default: rxState <= vcub_pkg::VCUB_IDLE;
         endcase
      end
   end
   // Receive holding buffer; new data wins over a read in the same cycle
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rxData <= 8'h00;
         rxValid <= 1'b0;
         rxOverrun <= 1'b0;
         rxFrameErr <= 1'b0;
      end else begin
         if (rxDone) begin
            if (rxValid && !rxTake) begin
               rxOverrun <= 1'b1;
            end else begin
               rxData <= rxShift;
               rxValid <= 1'b1;
            end
            if (!rxStopOk) begin
               rxFrameErr <= 1'b1;
            end
         end else if (rxTake) begin
            rxValid <= 1'b0;
         end
      end
   end
   // Clear-to-send toward the target
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         targetCts <= 1'b0;
         targetCtsOe <= 1'b0;
      end else begin
         targetCtsOe <= drivesCts(hsMode);
         targetCts <= !rxValid;
      end
   end
   // Transmitter toward the target input line
   vcub_pkg::vcub_state_e txState;
   logic [3:0] txPhase;
   logic [2:0] txBit;
   logic [7:0] txShift, txHold;
   logic txHoldValid, txLoad, txGo, txPut;
   // Request-to-send gates only the start of a new character
   assign txGo = txHoldValid && linkOn && (!honoursRts(hsMode) || rtsIn);
   assign txLoad = tick && (txState == vcub_pkg::VCUB_IDLE) && txGo;
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         txState <= vcub_pkg::VCUB_IDLE;
         txPhase <= 4'h0;
         txBit <= 3'h0;
         txShift <= 8'h00;
         targetRx <= 1'b1;
      end else if (tick) begin
         txPhase <= txPhase + 4'h1;
         case (txState)
            vcub_pkg::VCUB_IDLE: begin
               targetRx <= 1'b1;
               txPhase <= 4'h0;
               if (txGo) begin
                  txShift <= txHold;
                  targetRx <= 1'b0;
                  txState <= vcub_pkg::VCUB_START;
               end
            end
            vcub_pkg::VCUB_START: begin
               if (txPhase == 4'hf) begin
                  targetRx <= txShift[0];
                  txShift <= {1'b0, txShift[7:1]};
                  txBit <= 3'h0;
                  txState <= vcub_pkg::VCUB_DATA;
               end
            end
            vcub_pkg::VCUB_DATA: begin
               if (txPhase == 4'hf) begin
                  txBit <= txBit + 3'h1;
                  if (txBit == 3'h7) begin
                     targetRx <= 1'b1;
                     txState <= vcub_pkg::VCUB_STOP;
                  end else begin
                     targetRx <= txShift[0];
                     txShift <= {1'b0, txShift[7:1]};
                  end
               end
            end
            vcub_pkg::VCUB_STOP: begin
               // Completes even if request-to-send has dropped
               if (txPhase == 4'hf) begin
                  txState <= vcub_pkg::VCUB_IDLE;
               end
            end
            default: txState <= vcub_pkg::VCUB_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         txHold <= 8'h00;
         txHoldValid <= 1'b0;
      end else if (txPut) begin
         txHold <= s_axi_wdata[7:0];
         txHoldValid <= 1'b1;
      end else if (txLoad) begin
         txHoldValid <= 1'b0;
      end
   end
   // Host path selection: a connected socket takes priority
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         socketPathActive <= 1'b0;
         usbPathActive <= 1'b0;
      end else begin
         socketPathActive <= ctrlReg[vcub_pkg::CTRL_SOCK_BIT];
         usbPathActive <= !ctrlReg[vcub_pkg::CTRL_SOCK_BIT];
      end
   end

   // AXI4-Lite write channel
   logic awHeld, wHeld, doWrite;
   logic [7:0] awAddr;
   assign s_axi_awready = !awHeld && !s_axi_bvalid;
   assign s_axi_wready = !wHeld && !s_axi_bvalid;
   assign doWrite = (awHeld || s_axi_awvalid) && (wHeld || s_axi_wvalid) && !s_axi_bvalid;
   logic [7:0] wAddr;
   assign wAddr = awHeld ? awAddr : s_axi_awaddr;
   logic [31:0] wData;
   logic [3:0] wStrb;
   logic [31:0] wDataHeld;
   logic [3:0] wStrbHeld;
   assign wData = wHeld ? wDataHeld : s_axi_wdata;
   assign wStrb = wHeld ? wStrbHeld : s_axi_wstrb;
   assign txPut = doWrite && (wAddr == vcub_pkg::ADDR_TXDATA) && wStrb[0] && !txHoldValid;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awAddr <= 8'h00;
         wDataHeld <= 32'h0;
         wStrbHeld <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= vcub_pkg::AXI_OKAY;
      end else if (doWrite) begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         s_axi_bvalid <= 1'b1;
         if (wAddr == vcub_pkg::ADDR_CTRL || wAddr == vcub_pkg::ADDR_BAUD ||
             wAddr == vcub_pkg::ADDR_TXDATA) begin
            s_axi_bresp <= vcub_pkg::AXI_OKAY;
         end else begin
            s_axi_bresp <= vcub_pkg::AXI_SLVERR;
         end
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld <= 1'b1;
            awAddr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld <= 1'b1;
            wDataHeld <= s_axi_wdata;
            wStrbHeld <= s_axi_wstrb;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ctrlReg <= vcub_pkg::CTRL_RESET;
         divReg <= DIV_RESET;
      end else if (doWrite) begin
         if (wAddr == vcub_pkg::ADDR_CTRL && wStrb[0]) begin
            ctrlReg <= wData[2:0];
         end else if (wAddr == vcub_pkg::ADDR_BAUD) begin
            if (wStrb[0]) begin
               divReg[7:0] <= wData[7:0];
            end
            if (wStrb[1]) begin
               divReg[15:8] <= wData[15:8];
            end
         end
      end
   end
   // AXI4-Lite read channel
   assign s_axi_arready = !s_axi_rvalid;
   assign rxTake = s_axi_arvalid && s_axi_arready && (s_axi_araddr == vcub_pkg::ADDR_RXDATA);
   logic [31:0] statusWord;
   always_comb begin
      statusWord = 32'h0;
      statusWord[vcub_pkg::ST_RXVALID] = rxValid;
      statusWord[vcub_pkg::ST_TXBUSY] = txHoldValid || (txState != vcub_pkg::VCUB_IDLE);
      statusWord[vcub_pkg::ST_RXFULL] = rxValid;
      statusWord[vcub_pkg::ST_OVERRUN] = rxOverrun;
      statusWord[vcub_pkg::ST_FRAMEERR] = rxFrameErr;
      statusWord[vcub_pkg::ST_RTSIN] = rtsIn;
      statusWord[vcub_pkg::ST_ENABLE] = linkOn;
   end
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= vcub_pkg::AXI_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= vcub_pkg::AXI_OKAY;
         if (s_axi_araddr == vcub_pkg::ADDR_CTRL) begin
            s_axi_rdata <= {29'h0, ctrlReg};
         end else if (s_axi_araddr == vcub_pkg::ADDR_BAUD) begin
            s_axi_rdata <= {16'h0, divReg};
         end else if (s_axi_araddr == vcub_pkg::ADDR_STATUS) begin
            s_axi_rdata <= statusWord;
         end else if (s_axi_araddr == vcub_pkg::ADDR_TXDATA) begin
            s_axi_rdata <= {24'h0, txHold};
         end else if (s_axi_araddr == vcub_pkg::ADDR_RXDATA) begin
            s_axi_rdata <= {24'h0, rxData};
         end else begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= vcub_pkg::AXI_SLVERR;
         end
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* File: verilog/vcub_pkg.sv */
// Package of constants for the virtual COM UART flow bridge
package vcub_pkg;
   localparam int CLK_HZ = 40000000;
   localparam int BAUD_DEFAULT = 115200;
   localparam int BAUD_MIN = 9600;
   localparam int BAUD_MAX = 921600;
   localparam int SOCKET_PORT = 4901;
   localparam int DIV_W = 16;
   // Divider value is clocks per sixteenth of a bit, minus one
   localparam logic [15:0] DIV_DEFAULT = 16'(CLK_HZ / (BAUD_DEFAULT * 16) - 1);
   localparam logic [15:0] DIV_MAX = 16'(CLK_HZ / (BAUD_MIN * 16) - 1);
   localparam logic [15:0] DIV_MIN = 16'(CLK_HZ / (BAUD_MAX * 16) - 1);
   // Register byte addresses
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_BAUD = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_TXDATA = 8'h0c;
   localparam logic [7:0] ADDR_RXDATA = 8'h10;
   // Control fields
   localparam int CTRL_HS_LSB = 0;
   localparam int CTRL_SOCK_BIT = 2;
   localparam logic [2:0] CTRL_RESET = 3'h0;
   // Status fields
   localparam int ST_RXVALID = 0;
   localparam int ST_TXBUSY = 1;
   localparam int ST_RXFULL = 2;
   localparam int ST_OVERRUN = 3;
   localparam int ST_FRAMEERR = 4;
   localparam int ST_RTSIN = 5;
   localparam int ST_ENABLE = 6;
   localparam logic [1:0] AXI_OKAY = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;
   typedef enum logic [1:0] {
      VCUB_HS_DISABLE = 2'h0,
      VCUB_HS_RTS = 2'h1,
      VCUB_HS_CTS = 2'h2,
      VCUB_HS_RTSCTS = 2'h3
   } vcub_hs_e;
   typedef enum logic [1:0] {
      VCUB_IDLE = 2'h0,
      VCUB_START = 2'h1,
      VCUB_DATA = 2'h3,
      VCUB_STOP = 2'h2
   } vcub_state_e;
endpackage

/* File: test/vcub_checker.sv */
// Assertion checker on the flow bridge ports
`timescale 1ns/1ps
`default_nettype none
module vcub_checker #(
   parameter logic [15:0] DIV_RESET = vcub_pkg::DIV_DEFAULT
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic targetRx,
   input wire logic targetRts,
   input wire logic targetCts,
   input wire logic targetCtsOe,
   input wire logic bridgeEnable,
   input wire logic usbPathActive,
   input wire logic socketPathActive
);
   // One whole frame plus margin for the input synchronisers
   localparam int LIM = 160 * (int'(DIV_RESET) + 1) + 8;
   logic [2:0] ctrlShadow;
   logic [7:0] rdAddr;
   int rtsLowCnt;
   int enLowCnt;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   always_ff @(posedge clk_sys) begin
      if (!rst_n) ctrlShadow <= 3'h0;
      else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
         && s_axi_awaddr == vcub_pkg::ADDR_CTRL) ctrlShadow <= s_axi_wdata[2:0];
   end
   always_ff @(posedge clk_sys) begin
      if (s_axi_arvalid && s_axi_arready) rdAddr <= s_axi_araddr;
   end
   always_ff @(posedge clk_sys) begin
      if (!rst_n || targetRts || !ctrlShadow[1]) rtsLowCnt <= 0;
      else if (rtsLowCnt <= LIM) rtsLowCnt <= rtsLowCnt + 1;
   end
   always_ff @(posedge clk_sys) begin
      if (!rst_n || bridgeEnable) enLowCnt <= 0;
      else if (enLowCnt <= LIM) enLowCnt <= enLowCnt + 1;
   end
   reset_idle_a: assert property ($rose(rst_n) |-> targetRx && !targetCtsOe && !socketPathActive)
      else $error("link not idle after reset");
   path_excl_a: assert property ($past(rst_n) |-> usbPathActive != socketPathActive)
      else $error("host paths not exclusive");
   sock_follow_a: assert property ($rose(s_axi_bvalid) |=> socketPathActive == ctrlShadow[2])
      else $error("socket path does not follow control");
   oe_mode_a: assert property ($rose(s_axi_bvalid) |=> targetCtsOe == ctrlShadow[0])
      else $error("clear-to-send drive does not follow mode");
   start_len_a: assert property ($fell(targetRx) |=> !targetRx [*8])
      else $error("low period on serial output too short");
   cts_full_a: assert property (s_axi_rvalid && rdAddr == vcub_pkg::ADDR_STATUS
      && s_axi_rdata[vcub_pkg::ST_RXFULL] |-> !targetCts)
      else $error("clear-to-send high while receive full");
   rts_gate_a: assert property (rtsLowCnt > LIM |-> targetRx)
      else $error("sending while request-to-send low");
   enable_gate_a: assert property (enLowCnt > LIM |-> targetRx)
      else $error("sending while enable low");
endmodule
bind vcub_bridge vcub_checker #(.DIV_RESET(DIV_RESET)) i_vcub_checker (
   .clk_sys(clk_sys), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .targetRx(targetRx),
   .targetRts(targetRts), .targetCts(targetCts), .targetCtsOe(targetCtsOe),
   .bridgeEnable(bridgeEnable), .usbPathActive(usbPathActive),
   .socketPathActive(socketPathActive));
`default_nettype wire

/* File: test/vcub_target.sv */
// Behavioural model of the target processor UART
`timescale 1ns/1ps
`default_nettype none
module vcub_target #(
   parameter int BIT = 64
) (
   input wire logic clk_sys,
   input wire logic targetRx,
   input wire logic ctsWire,
   output logic targetTx,
   output logic targetRts
);
   logic [7:0] rxByte;
   logic rtsWant;
   int rxCnt;
   assign targetRts = rtsWant;
   initial begin
      targetTx = 1'h1;
      rtsWant = 1'h1;
      rxCnt = 0;
      rxByte = 8'h00;
      // Always takes a started character, even after dropping request-to-send
      forever begin
         @(negedge targetRx);
         repeat (BIT / 2) @(posedge clk_sys);
         for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge clk_sys);
            rxByte[i] = targetRx;
         end
         repeat (BIT) @(posedge clk_sys);
         if (targetRx === 1'h1) rxCnt++;
      end
   end
   task automatic sendByte(input logic [7:0] b, input logic hs, output logic late);
      logic [9:0] f;
      int n;
      f = {1'h1, b, 1'h0};
      for (n = 0; n < 5000 && hs && ctsWire !== 1'h1; n++) @(posedge clk_sys);
      late = (n == 5000);
      for (int i = 0; i < 10; i++) begin
         targetTx <= f[i];
         repeat (BIT) @(posedge clk_sys);
      end
   endtask
endmodule
`default_nettype wire

/* File: test/vcub_bridge_tb.sv */
// Self-checking bench for the flow bridge
`timescale 1ns/1ps
`default_nettype none
module vcub_bridge_tb;
   localparam logic [15:0] DIV = 16'h0003;
   localparam int BIT = 16 * (int'(DIV) + 1);
   logic clk_sys, rst_n, bridgeEnable, ctsWire, late;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rv;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic targetTx, targetRx, targetRts, targetCts, targetCtsOe, usbPathActive, socketPathActive;
   int errorCnt, checkCount;
   // Undriven clear-to-send line is pulled high
   assign ctsWire = targetCtsOe ? targetCts : 1'h1;
   vcub_bridge #(.DIV_RESET(DIV)) i_vcub_bridge (
      .clk_sys(clk_sys), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .targetTx(targetTx), .targetRx(targetRx),
      .targetRts(targetRts), .targetCts(targetCts), .targetCtsOe(targetCtsOe),
      .bridgeEnable(bridgeEnable), .usbPathActive(usbPathActive),
      .socketPathActive(socketPathActive));
   vcub_target #(.BIT(BIT)) i_vcub_target (.clk_sys(clk_sys), .targetRx(targetRx),
      .ctsWire(ctsWire), .targetTx(targetTx), .targetRts(targetRts));
   initial begin
      clk_sys = 1'h0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      checkCount++;
      if (s !== e) begin
         errorCnt++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic results;
      $display("checks %0d errors %0d", checkCount, errorCnt);
      if (errorCnt == 0 && checkCount > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic tmo;
      errorCnt++;
      $display("Error wait expected done seen timeout");
      results();
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      int n;
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk_sys);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid) break;
      end
      if (n == 50) tmo();
      s_axi_bready <= 1'h0;
      chk("bresp", 32'(s_axi_bresp), 32'(r));
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] r);
      int n;
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk_sys);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid) break;
      end
      if (n == 50) tmo();
      s_axi_rready <= 1'h0;
      d = s_axi_rdata;
      chk("rresp", 32'(s_axi_rresp), 32'(r));
   endtask
   task automatic waitRx(input int c);
      int n;
      for (n = 0; n < 30 * BIT; n++) begin
         @(posedge clk_sys);
         if (i_vcub_target.rxCnt != c) break;
      end
      if (n == 30 * BIT) tmo();
   endtask
   task automatic t_reset;
      chk("targetRx", 32'(targetRx), 32'h1);
      chk("ctsOe", 32'(targetCtsOe), 32'h0);
      chk("usb", 32'(usbPathActive), 32'h1);
      rd(vcub_pkg::ADDR_CTRL, rv, vcub_pkg::AXI_OKAY);
      chk("ctrl", rv & 32'h7, 32'h0);
      rd(vcub_pkg::ADDR_BAUD, rv, vcub_pkg::AXI_OKAY);
      chk("baud", rv & 32'hffff, 32'(DIV));
      rd(8'h20, rv, vcub_pkg::AXI_SLVERR);
   endtask
   task automatic t_tx;
      int c;
      c = i_vcub_target.rxCnt;
      i_vcub_target.rtsWant <= 1'h0;
      wr(vcub_pkg::ADDR_TXDATA, 32'ha5, vcub_pkg::AXI_OKAY);
      waitRx(c);
      chk("rxByte", 32'(i_vcub_target.rxByte), 32'ha5);
   endtask
   task automatic t_cts;
      int c;
      wr(vcub_pkg::ADDR_CTRL, 32'h2, vcub_pkg::AXI_OKAY);
      c = i_vcub_target.rxCnt;
      wr(vcub_pkg::ADDR_TXDATA, 32'h5a, vcub_pkg::AXI_OKAY);
      repeat (12 * BIT) @(posedge clk_sys);
      chk("held", 32'(i_vcub_target.rxCnt - c), 32'h0);
      i_vcub_target.rtsWant <= 1'h1;
      waitRx(c);
      chk("rxByte", 32'(i_vcub_target.rxByte), 32'h5a);
   endtask
   task automatic t_full;
      wr(vcub_pkg::ADDR_CTRL, 32'h1, vcub_pkg::AXI_OKAY);
      repeat (2) @(posedge clk_sys);
      chk("cts", 32'(ctsWire), 32'h1);
      i_vcub_target.sendByte(8'h3c, 1'h1, late);
      if (late) tmo();
      repeat (8) @(posedge clk_sys);
      chk("cts", 32'(ctsWire), 32'h0);
      rd(vcub_pkg::ADDR_STATUS, rv, vcub_pkg::AXI_OKAY);
      chk("full", 32'(rv[vcub_pkg::ST_RXFULL]), 32'h1);
      rd(vcub_pkg::ADDR_RXDATA, rv, vcub_pkg::AXI_OKAY);
      chk("rxdata", rv & 32'hff, 32'h3c);
      repeat (4) @(posedge clk_sys);
      chk("cts", 32'(ctsWire), 32'h1);
   endtask
   task automatic t_rtscts;
      int c;
      int n;
      wr(vcub_pkg::ADDR_CTRL, 32'h3, vcub_pkg::AXI_OKAY);
      c = i_vcub_target.rxCnt;
      wr(vcub_pkg::ADDR_TXDATA, 32'h96, vcub_pkg::AXI_OKAY);
      for (n = 0; n < 4 * BIT && targetRx; n++) @(posedge clk_sys);
      if (n == 4 * BIT) tmo();
      i_vcub_target.rtsWant <= 1'h0;
      waitRx(c);
      chk("rxByte", 32'(i_vcub_target.rxByte), 32'h96);
      chk("ctsOe", 32'(targetCtsOe), 32'h1);
      i_vcub_target.rtsWant <= 1'h1;
   endtask
   task automatic t_socket;
      wr(vcub_pkg::ADDR_CTRL, 32'h4, vcub_pkg::AXI_OKAY);
      repeat (2) @(posedge clk_sys);
      chk("socket", 32'(socketPathActive), 32'h1);
      chk("usb", 32'(usbPathActive), 32'h0);
      wr(vcub_pkg::ADDR_CTRL, 32'h0, vcub_pkg::AXI_OKAY);
   endtask
   task automatic t_enable;
      int c;
      bridgeEnable <= 1'h0;
      repeat (2) @(posedge clk_sys);
      c = i_vcub_target.rxCnt;
      // A byte queued while disabled must wait for the enable
      wr(vcub_pkg::ADDR_TXDATA, 32'h69, vcub_pkg::AXI_OKAY);
      i_vcub_target.sendByte(8'hc3, 1'h0, late);
      repeat (BIT) @(posedge clk_sys);
      rd(vcub_pkg::ADDR_STATUS, rv, vcub_pkg::AXI_OKAY);
      chk("rxvalid", 32'(rv[vcub_pkg::ST_RXVALID]), 32'h0);
      chk("held", 32'(i_vcub_target.rxCnt - c), 32'h0);
      bridgeEnable <= 1'h1;
      waitRx(c);
      chk("rxByte", 32'(i_vcub_target.rxByte), 32'h69);
   endtask
   initial begin
      rst_n = 1'h0;
      bridgeEnable = 1'h1;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
      errorCnt = 0;
      checkCount = 0;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'h1;
      repeat (2) @(posedge clk_sys);
      t_reset();
      t_tx();
      t_cts();
      t_full();
      t_rtscts();
      t_socket();
      t_enable();
      results();
   end
endmodule
`default_nettype wire
